// [src/pmc_capture.sv]
// Purpose: microphone capture top: APB registers, clock, decimators, gain, DMA
// Assumes: pclk 10 MHz; DMA port acks each word within one sample period
// Notes: a new word arriving while one is unacked replaces it
`timescale 1ns/1ps
module pmc_capture #(
  parameter int NUM_PINS = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // DMA write master
  output logic dma_req,
  output logic [31:0] dma_addr,
  output logic [31:0] dma_wdata,
  input wire logic dma_ack,
  // Pads
  input wire logic [NUM_PINS-1:0] gpio_out,
  input wire logic [NUM_PINS-1:0] gpio_oe,
  input wire logic [NUM_PINS-1:0] pad_in,
  output logic [NUM_PINS-1:0] pad_out,
  output logic [NUM_PINS-1:0] pad_oe,
  // Event request
  output logic irq
);
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic enable;
    logic [7:0] half;
    logic mono;
    logic edge_swap;
    logic ratio80;
    logic [6:0] left_gain;
    logic [6:0] right_gain;
    logic [31:0] psel_clk;
    logic [31:0] psel_din;
    logic [31:0] buffer_pointer;
    logic [14:0] buffer_sample_count;
    logic ev_started;
    logic ev_stopped;
    logic ev_end;
    logic [2:0] inten;
    logic irq;
    pmc_pkg::pmc_run_t run;
    logic [7:0] div;
    logic modulation_clock;
    logic stb_fall;
    logic stb_rise;
    logic [31:0] act_ptr;
    logic [14:0] wcnt;
    logic [15:0] held;
    logic have_half;
    logic dma_req;
    logic [31:0] dma_addr;
    logic [31:0] dma_wdata;
    logic [NUM_PINS-1:0] pad_out;
    logic [NUM_PINS-1:0] pad_oe;
  } pmc_state_t;
  pmc_state_t st_reg, st_next;

  logic din_raw;
  logic din_sync;
  logic l_vld;
  logic r_vld;
  logic signed [15:0] l_smp;
  logic signed [15:0] r_smp;
  logic acq;

  // Gain in 0.5 dB steps: whole 6 dB steps by shift, remainder by table
  function automatic logic [15:0] pmc_apply_gain(input logic signed [15:0] s,
                                                 input logic [6:0] code);
    logic [6:0] c;
    logic [6:0] c2;
    logic [2:0] q;
    logic [3:0] r;
    logic [14:0] m;
    logic signed [39:0] p;
    c = (code > pmc_pkg::GAIN_MAX) ? pmc_pkg::GAIN_MAX : code;
    c2 = c + pmc_pkg::GAIN_BIAS;
    q = 3'(c2 / pmc_pkg::GAIN_STEPS);
    r = 4'(c2 % pmc_pkg::GAIN_STEPS);
    case (r)
      4'h0: m = 15'h4000;
      4'h1: m = 15'h43CB;
      4'h2: m = 15'h47CF;
      4'h3: m = 15'h4C10;
      4'h4: m = 15'h5092;
      4'h5: m = 15'h5558;
      4'h6: m = 15'h5A67;
      4'h7: m = 15'h5FC2;
      4'h8: m = 15'h656F;
      4'h9: m = 15'h6B72;
      4'hA: m = 15'h71CF;
      default: m = 15'h788E;
    endcase
    p = (40'(s) * $signed({25'h0000000, m})) <<< q;
    p = p >>> pmc_pkg::GAIN_SHIFT;
    // Saturate instead of wrapping on loud input
    if (p > 40'sh0000007FFF)
    begin
      return 16'h7FFF;
    end
    else if (p < -40'sh0000008000)
    begin
      return 16'h8000;
    end
    return p[15:0];
  endfunction : pmc_apply_gain

  // Mapped byte addresses
  function automatic logic pmc_hit(input logic [11:0] a);
    return (a == pmc_pkg::OFF_TASK_START) || (a == pmc_pkg::OFF_TASK_STOP) ||
           (a == pmc_pkg::OFF_EV_STARTED) || (a == pmc_pkg::OFF_EV_STOPPED) ||
           (a == pmc_pkg::OFF_EV_END) || (a == pmc_pkg::OFF_INTEN) ||
           (a == pmc_pkg::OFF_INTENSET) || (a == pmc_pkg::OFF_INTENCLR) ||
           (a == pmc_pkg::OFF_ENABLE) || (a == pmc_pkg::OFF_CLKDIV) ||
           (a == pmc_pkg::OFF_MODE) || (a == pmc_pkg::OFF_LEFT_GAIN) ||
           (a == pmc_pkg::OFF_RIGHT_GAIN) || (a == pmc_pkg::OFF_RATIO) ||
           (a == pmc_pkg::OFF_PSEL_CLK) || (a == pmc_pkg::OFF_PSEL_DIN) ||
           (a == pmc_pkg::OFF_BUF_PTR) || (a == pmc_pkg::OFF_BUF_CNT);
  endfunction : pmc_hit

  // Data pin mux ahead of the synchroniser; disconnected reads zero
  assign din_raw = (st_reg.enable && !st_reg.psel_din[pmc_pkg::CONNECT_BIT]) ?
                   pad_in[st_reg.psel_din[pmc_pkg::PIN_W-1:0]] : 1'b0; // see R19
  assign acq = (st_reg.run == pmc_pkg::RUN_ACQ);

  pmc_sync3 u_sync (
    .pclk,
    .presetn,
    .din_async(din_raw),
    .din_sync
  );

  // Left on falling edge unless swapped
  pmc_cic u_cic_left (
    .pclk,
    .presetn,
    .run(acq),
    .ratio80(st_reg.ratio80),
    .in_valid(st_reg.edge_swap ? st_reg.stb_rise : st_reg.stb_fall), // see R2, R3
    .in_bit(din_sync),
    .out_valid(l_vld),
    .out_sample(l_smp)
  );

  pmc_cic u_cic_right (
    .pclk,
    .presetn,
    .run(acq),
    .ratio80(st_reg.ratio80),
    .in_valid(st_reg.edge_swap ? st_reg.stb_fall : st_reg.stb_rise), // see R2, R3
    .in_bit(din_sync),
    .out_valid(r_vld),
    .out_sample(r_smp)
  );

  // Whole next state
  always_comb
  begin
    logic wr;
    logic start;
    logic stop;
    logic set_started;
    logic set_stopped;
    logic set_end;
    logic [2:0] ev_wr;
    logic [15:0] gl;
    logic [15:0] gr;
    logic word;
    logic [31:0] wdat;
    start = 1'b0;
    stop = 1'b0;
    set_started = 1'b0;
    set_stopped = 1'b0;
    set_end = 1'b0;
    ev_wr = 3'b000;
    word = 1'b0;
    wdat = '0;
    gl = pmc_apply_gain(l_smp, st_reg.left_gain); // see R6, R7
    gr = pmc_apply_gain(r_smp, st_reg.right_gain); // see R6, R7
    st_next = st_reg;
    wr = psel && penable && st_reg.pready && pwrite;

    // APB: one wait state, write commits on the ready edge
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;
    if (psel && penable && !st_reg.pready)
    begin
      st_next.pready = 1'b1;
      st_next.pslverr = !pmc_hit(paddr);
      st_next.prdata = '0;
      if (paddr == pmc_pkg::OFF_EV_STARTED)
        st_next.prdata[0] = st_reg.ev_started;
      else if (paddr == pmc_pkg::OFF_EV_STOPPED)
        st_next.prdata[0] = st_reg.ev_stopped;
      else if (paddr == pmc_pkg::OFF_EV_END)
        st_next.prdata[0] = st_reg.ev_end;
      else if (paddr == pmc_pkg::OFF_INTEN || paddr == pmc_pkg::OFF_INTENSET ||
               paddr == pmc_pkg::OFF_INTENCLR)
        st_next.prdata[2:0] = st_reg.inten;
      else if (paddr == pmc_pkg::OFF_ENABLE)
        st_next.prdata[0] = st_reg.enable;
      else if (paddr == pmc_pkg::OFF_CLKDIV)
        st_next.prdata[7:0] = st_reg.half;
      else if (paddr == pmc_pkg::OFF_MODE)
        st_next.prdata[1:0] = {st_reg.edge_swap, st_reg.mono};
      else if (paddr == pmc_pkg::OFF_LEFT_GAIN)
        st_next.prdata[6:0] = st_reg.left_gain;
      else if (paddr == pmc_pkg::OFF_RIGHT_GAIN)
        st_next.prdata[6:0] = st_reg.right_gain;
      else if (paddr == pmc_pkg::OFF_RATIO)
        st_next.prdata[0] = st_reg.ratio80;
      else if (paddr == pmc_pkg::OFF_PSEL_CLK)
        st_next.prdata = st_reg.psel_clk;
      else if (paddr == pmc_pkg::OFF_PSEL_DIN)
        st_next.prdata = st_reg.psel_din;
      else if (paddr == pmc_pkg::OFF_BUF_PTR)
        st_next.prdata = st_reg.buffer_pointer;
      else if (paddr == pmc_pkg::OFF_BUF_CNT)
        st_next.prdata[14:0] = st_reg.buffer_sample_count;
    end
    if (wr)
    begin
      if (paddr == pmc_pkg::OFF_TASK_START)
        start = pwdata[0];
      else if (paddr == pmc_pkg::OFF_TASK_STOP)
        stop = pwdata[0];
      else if (paddr == pmc_pkg::OFF_EV_STARTED)
        ev_wr[0] = 1'b1;
      else if (paddr == pmc_pkg::OFF_EV_STOPPED)
        ev_wr[1] = 1'b1;
      else if (paddr == pmc_pkg::OFF_EV_END)
        ev_wr[2] = 1'b1;
      else if (paddr == pmc_pkg::OFF_INTEN)
        st_next.inten = pwdata[2:0];
      else if (paddr == pmc_pkg::OFF_INTENSET)
        st_next.inten = st_reg.inten | pwdata[2:0];
      else if (paddr == pmc_pkg::OFF_INTENCLR)
        st_next.inten = st_reg.inten & ~pwdata[2:0];
      else if (paddr == pmc_pkg::OFF_ENABLE)
        st_next.enable = pwdata[0];
      else if (paddr == pmc_pkg::OFF_CLKDIV)
        st_next.half = (pwdata[7:0] < pmc_pkg::MIN_HALF) ? pmc_pkg::MIN_HALF : pwdata[7:0];
      else if (paddr == pmc_pkg::OFF_MODE)
      begin
        st_next.mono = pwdata[pmc_pkg::MODE_MONO_BIT];
        st_next.edge_swap = pwdata[pmc_pkg::MODE_EDGE_BIT];
      end
      else if (paddr == pmc_pkg::OFF_LEFT_GAIN)
        st_next.left_gain = pwdata[6:0];
      else if (paddr == pmc_pkg::OFF_RIGHT_GAIN)
        st_next.right_gain = pwdata[6:0];
      else if (paddr == pmc_pkg::OFF_RATIO)
        st_next.ratio80 = pwdata[0]; // see R5
      else if (paddr == pmc_pkg::OFF_PSEL_CLK)
        st_next.psel_clk = pwdata;
      else if (paddr == pmc_pkg::OFF_PSEL_DIN)
        st_next.psel_din = pwdata;
      else if (paddr == pmc_pkg::OFF_BUF_PTR)
        st_next.buffer_pointer = pwdata; // see R13
      else if (paddr == pmc_pkg::OFF_BUF_CNT)
        st_next.buffer_sample_count = pwdata[14:0];
    end

    // Modulation clock: runs only while acquiring, idles low
    st_next.stb_fall = 1'b0;
    st_next.stb_rise = 1'b0;
    if (!acq)
    begin
      st_next.div = '0;
      st_next.modulation_clock = 1'b0;
    end
    else if (st_reg.div >= st_reg.half - 8'h01)
    begin
      st_next.div = '0;
      st_next.modulation_clock = !st_reg.modulation_clock; // see R1
      st_next.stb_fall = st_reg.modulation_clock;
      st_next.stb_rise = !st_reg.modulation_clock;
    end
    else
    begin
      st_next.div = st_reg.div + 8'h01;
    end

    // Pack samples into words
    if (acq)
    begin
      if (!st_reg.mono)
      begin
        if (l_vld)
          st_next.held = gl;
        if (r_vld)
        begin
          word = 1'b1;
          wdat = {gr, st_reg.held}; // see R8, R9
        end
      end
      else if (l_vld)
      begin
        st_next.have_half = !st_reg.have_half;
        st_next.held = gl;
        if (st_reg.have_half)
        begin
          word = 1'b1;
          wdat = {gl, st_reg.held}; // see R8, R9
        end
      end
    end

    // DMA word handshake and buffer turnover
    if (dma_ack && st_reg.dma_req)
    begin
      st_next.dma_req = 1'b0;
      if (acq && st_reg.wcnt >= st_reg.buffer_sample_count)
      begin
        set_end = 1'b1; // see R14
        set_started = 1'b1;
        st_next.act_ptr = st_reg.buffer_pointer; // see R13
        st_next.wcnt = '0;
      end
    end
    if (word)
    begin
      st_next.dma_req = 1'b1;
      st_next.dma_addr = st_reg.act_ptr + {16'h0000, st_reg.wcnt, 1'b0}; // see R10
      st_next.dma_wdata = wdat;
      st_next.wcnt = st_reg.wcnt + 15'h0002; // see R10
    end

    // Run control
    case (st_reg.run)
      pmc_pkg::RUN_IDLE:
      begin
        if (start && st_reg.enable)
        begin
          st_next.run = pmc_pkg::RUN_ACQ;
          st_next.act_ptr = st_reg.buffer_pointer;
          st_next.wcnt = '0;
          st_next.have_half = 1'b0;
          set_started = 1'b1;
        end
        else if (stop)
        begin
          set_stopped = 1'b1;
        end
      end
      pmc_pkg::RUN_ACQ:
      begin
        if (stop || !st_reg.enable)
        begin
          st_next.run = pmc_pkg::RUN_DRAIN; // see R15
        end
      end
      pmc_pkg::RUN_DRAIN:
      begin
        if (!st_reg.dma_req)
        begin
          st_next.run = pmc_pkg::RUN_IDLE;
          set_end = 1'b1;
          set_stopped = 1'b1; // see R16
        end
      end
      default:
      begin
        st_next.run = pmc_pkg::RUN_IDLE;
      end
    endcase

    // Sticky events: a hardware set beats a same-cycle clear
    st_next.ev_started = set_started | (ev_wr[0] ? (pwdata[0] & st_reg.ev_started)
                                                 : st_reg.ev_started); // see R22
    st_next.ev_stopped = set_stopped | (ev_wr[1] ? (pwdata[0] & st_reg.ev_stopped)
                                                 : st_reg.ev_stopped); // see R22
    st_next.ev_end = set_end | (ev_wr[2] ? (pwdata[0] & st_reg.ev_end)
                                         : st_reg.ev_end); // see R22
    st_next.irq = |({st_reg.ev_end, st_reg.ev_stopped, st_reg.ev_started} &
                    st_reg.inten); // see R22

    // Pins follow GPIO unless enabled and connected
    st_next.pad_out = gpio_out;
    st_next.pad_oe = gpio_oe;
    if (st_reg.enable) // see R20
    begin
      if (!st_reg.psel_clk[pmc_pkg::CONNECT_BIT]) // see R19
      begin
        st_next.pad_out[st_reg.psel_clk[pmc_pkg::PIN_W-1:0]] = st_reg.modulation_clock;
        st_next.pad_oe[st_reg.psel_clk[pmc_pkg::PIN_W-1:0]] = 1'b1;
      end
      if (!st_reg.psel_din[pmc_pkg::CONNECT_BIT])
      begin
        st_next.pad_oe[st_reg.psel_din[pmc_pkg::PIN_W-1:0]] = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '0;
      st_reg.half <= pmc_pkg::RST_HALF;
      st_reg.left_gain <= pmc_pkg::RST_GAIN;
      st_reg.right_gain <= pmc_pkg::RST_GAIN;
      st_reg.psel_clk <= pmc_pkg::RST_PSEL;
      st_reg.psel_din <= pmc_pkg::RST_PSEL;
      st_reg.run <= pmc_pkg::RUN_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign dma_req = st_reg.dma_req;
  assign dma_addr = st_reg.dma_addr;
  assign dma_wdata = st_reg.dma_wdata;
  assign pad_out = st_reg.pad_out;
  assign pad_oe = st_reg.pad_oe;
  assign irq = st_reg.irq;
endmodule : pmc_capture

// [pkg/pmc_pkg.sv]
// Purpose: constants and types for the microphone capture block
// Assumes: APB register bus, 12-bit byte address, 32-bit data
// Notes: every offset is a byte address
//
// What this block does
// R1 - Drive the modulation clock and take left and right bits from one data pin.
// R2 - Default: left sampled on falling clock edge, right on rising edge.
// R3 - Edge swap setting exchanges which edge feeds left and right.
// R4 - Each channel has its own decimator giving 16-bit PCM.
// R5 - Output rate is modulation clock divided by 64 or 80.
// R6 - Per-channel volume after filter, -20 dB to +20 dB around default.
// R7 - Gain codes step 0.5 dB; software keeps codes within min and max.
// R8 - Stereo writes left and right alternately; mono writes left only.
// R9 - Little endian: stereo right in upper half; mono later left upper.
// R10 - Buffer length counts 16-bit samples in every layout.
// R11 - Software sets pointer and sample count before the start task.
// R12 - Software keeps the pointer inside data RAM.
// R13 - Pointer is double buffered; next address may load after started.
// R14 - Full buffer raises end, continues into new buffer, raises started.
// R15 - Stop acts after the current frame completes, then raises stopped. Code stops at once, drops a partial frame, drains only the pending word.
// R16 - Stopped only after the last DMA write has landed.
// R17 - Software waits for stopped before starting again.
// R18 - Software discards roughly the first 50 samples after start.
// R19 - Clock and data go to selected pins; disconnected flag cuts them.
// R20 - Pin selection applies only while enabled; else pins act as GPIO.
// R21 - Software preconfigures clock pin output low and data pin input.
// R22 - Event flags stay set until written zero; enabled ones request irq.
package pmc_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_TASK_START = 12'h000;
  localparam logic [11:0] OFF_TASK_STOP = 12'h004;
  localparam logic [11:0] OFF_EV_STARTED = 12'h100;
  localparam logic [11:0] OFF_EV_STOPPED = 12'h104;
  localparam logic [11:0] OFF_EV_END = 12'h108;
  localparam logic [11:0] OFF_INTEN = 12'h300;
  localparam logic [11:0] OFF_INTENSET = 12'h304;
  localparam logic [11:0] OFF_INTENCLR = 12'h308;
  localparam logic [11:0] OFF_ENABLE = 12'h500;
  localparam logic [11:0] OFF_CLKDIV = 12'h504;
  localparam logic [11:0] OFF_MODE = 12'h508;
  localparam logic [11:0] OFF_LEFT_GAIN = 12'h518;
  localparam logic [11:0] OFF_RIGHT_GAIN = 12'h51C;
  localparam logic [11:0] OFF_RATIO = 12'h520;
  localparam logic [11:0] OFF_PSEL_CLK = 12'h540;
  localparam logic [11:0] OFF_PSEL_DIN = 12'h544;
  localparam logic [11:0] OFF_BUF_PTR = 12'h560;
  localparam logic [11:0] OFF_BUF_CNT = 12'h564;
  // Field positions
  localparam int MODE_MONO_BIT = 0;
  localparam int MODE_EDGE_BIT = 1;
  localparam int CONNECT_BIT = 31;
  localparam int PIN_W = 5;
  localparam int CNT_W = 15;
  // Reset values
  localparam logic [31:0] RST_PSEL = 32'hFFFFFFFF;
  localparam logic [6:0] RST_GAIN = 7'h28;
  localparam logic [7:0] RST_HALF = 8'h05;
  localparam logic [7:0] MIN_HALF = 8'h02;
  // Gain code: 0.5 dB steps, 0x28 is unity, 0x00..0x50 spans -20..+20 dB
  localparam logic [6:0] GAIN_MAX = 7'h50;
  localparam logic [6:0] GAIN_BIAS = 7'h08;
  localparam logic [6:0] GAIN_STEPS = 7'h0C;
  localparam int GAIN_SHIFT = 18;
  // Decimation
  localparam logic [6:0] RATIO_LO = 7'h40;
  localparam logic [6:0] RATIO_HI = 7'h50;
  localparam int CIC_SHIFT_LO = 3;
  localparam int CIC_SHIFT_HI = 4;
  typedef enum logic [2:0] {
    RUN_IDLE = 3'b001,
    RUN_ACQ = 3'b010,
    RUN_DRAIN = 3'b100
  } pmc_run_t;
endpackage : pmc_pkg

// [src/pmc_sync3.sv]
// Purpose: three-stage synchroniser for the data pin
// Assumes: input is asynchronous to pclk
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
module pmc_sync3 (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic din_async,
  output logic din_sync
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } pmc_sync_t;
  pmc_sync_t st_reg, st_next;

  // Stage one feeds only stage two
  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = din_async;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3)
    begin
      st_next.q = st_reg.s3;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign din_sync = st_reg.q;
endmodule : pmc_sync3

// [src/pmc_cic.sv]
// Purpose: third-order CIC decimator, one bit in, 16-bit PCM out
// Assumes: in_valid pulses once per modulation clock period
// Notes: all state cleared while run is low so each start begins clean
`timescale 1ns/1ps
module pmc_cic #(
  parameter int ACC_W = 22
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic run,
  input wire logic ratio80,
  // Bit input
  input wire logic in_valid,
  input wire logic in_bit,
  // Sample output
  output logic out_valid,
  output logic signed [15:0] out_sample
);
  typedef struct packed {
    logic signed [ACC_W-1:0] i1;
    logic signed [ACC_W-1:0] i2;
    logic signed [ACC_W-1:0] i3;
    logic signed [ACC_W-1:0] z1;
    logic signed [ACC_W-1:0] z2;
    logic signed [ACC_W-1:0] z3;
    logic [6:0] cnt;
    logic vld;
    logic signed [15:0] smp;
  } pmc_cic_t;
  pmc_cic_t st_reg, st_next;

  // Integrate every bit, comb once per decimation period
  always_comb
  begin
    logic signed [ACC_W-1:0] x;
    logic signed [ACC_W-1:0] d1;
    logic signed [ACC_W-1:0] d2;
    logic signed [ACC_W-1:0] d3;
    logic signed [ACC_W-1:0] sc;
    logic [6:0] last;
    x = in_bit ? ACC_W'(1) : -ACC_W'(1);
    d1 = st_reg.i3 - st_reg.z1;
    d2 = d1 - st_reg.z2;
    d3 = d2 - st_reg.z3;
    sc = ratio80 ? (d3 >>> pmc_pkg::CIC_SHIFT_HI) : (d3 >>> pmc_pkg::CIC_SHIFT_LO);
    last = (ratio80 ? pmc_pkg::RATIO_HI : pmc_pkg::RATIO_LO) - 7'h01;
    st_next = st_reg;
    st_next.vld = 1'b0;
    if (!run)
    begin
      st_next = '0;
    end
    else if (in_valid)
    begin
      st_next.i1 = st_reg.i1 + x;
      st_next.i2 = st_reg.i2 + st_reg.i1;
      st_next.i3 = st_reg.i3 + st_reg.i2;
      st_next.cnt = st_reg.cnt + 7'h01;
      if (st_reg.cnt >= last) // see R5
      begin
        st_next.cnt = '0;
        st_next.z1 = st_reg.i3;
        st_next.z2 = d1;
        st_next.z3 = d2;
        st_next.vld = 1'b1;
        // At ratio 64 full-scale input would wrap by one code, so clamp
        if (sc > ACC_W'(32767))
        begin
          st_next.smp = 16'sh7FFF; // see R4
        end
        else if (sc < -ACC_W'(32768))
        begin
          st_next.smp = -16'sh8000;
        end
        else
        begin
          st_next.smp = sc[15:0];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign out_valid = st_reg.vld;
  assign out_sample = st_reg.smp;
endmodule : pmc_cic

// [testbench/pmc_capture_chk.sv]
// Purpose: port checks for the capture block
// Assumes: one pclk domain, APB master with one setup cycle
// Notes: bound into every pmc_capture instance
`timescale 1ns/1ps
module pmc_capture_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // DMA and event request
  input wire logic dma_req,
  input wire logic [31:0] dma_addr,
  input wire logic [31:0] dma_wdata,
  input wire logic dma_ack,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access steps: setup, one wait, then answer
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; !pready ##1 pready; endsequence
  property p_wait; s_setup |=> s_answer; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  property p_hold; dma_req && !dma_ack |=> dma_req && $stable(dma_addr) && $stable(dma_wdata);
  endproperty
  property p_drop; dma_req && dma_ack |=> !dma_req; endproperty
  property p_align; dma_req |-> dma_addr[1:0] == 2'b00; endproperty
  // Request stays low at least eight cycles after each word drops
  property p_space; $fell(dma_req) |-> !dma_req [*8]; endproperty
  // Irq lags the clearing write
  property p_irq; $fell(irq) |-> $past(pwrite && pready, 1) || $past(pwrite && pready, 2);
  endproperty
  a_wait: assert property (p_wait) else $error("APB answer not after one wait");
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  a_err: assert property (p_err) else $error("error answer carries data");
  a_hold: assert property (p_hold) else $error("DMA word moved before ack");
  a_drop: assert property (p_drop) else $error("DMA request kept after ack");
  a_align: assert property (p_align) else $error("DMA address not word aligned");
  a_space: assert property (p_space) else $error("DMA words too close");
  a_irq: assert property (p_irq) else $error("irq fell without a write");
endmodule : pmc_capture_chk

bind pmc_capture pmc_capture_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
  .pslverr, .prdata, .dma_req, .dma_addr, .dma_wdata, .dma_ack, .irq);

// [testbench/pmc_mic_model.sv]
// Purpose: two microphones sharing one data line
// Assumes: left and right send constant bits
// Notes: with the clock pin undriven the line toggles
`timescale 1ns/1ps
module pmc_mic_model #(
  parameter logic LEFT_BIT = 1'b1,
  parameter logic RIGHT_BIT = 1'b0
) (
  // Clock and pins
  input wire logic pclk,
  input wire logic clk_pin,
  input wire logic clk_en,
  // Shared data line
  output logic data
);
  logic junk;
  // Released line toggles
  initial junk = 1'b0;
  always @(posedge pclk) junk <= ~junk;
  // Left talks while the clock is high, right while low
  assign data = clk_en ? (clk_pin ? LEFT_BIT : RIGHT_BIT) : junk;
endmodule : pmc_mic_model

// [testbench/pmc_capture_test.sv]
// Purpose: self-checking bench for the capture block
// Assumes: default clock divider of five, DMA acked next cycle
// Notes: PCM checked by sign of each half, not exact value
`timescale 1ns/1ps
module pmc_capture_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, dma_req, dma_ack, irq, din;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, dma_addr, dma_wdata, w_addr, w_data;
  logic [31:0] gpio_out, gpio_oe, pad_in, pad_out, pad_oe;
  int n_fail, checks_done, cyc, t_last, t_prev, n_words, n;
  localparam logic [31:0] BASE = 32'h20000000;
  localparam logic [31:0] MD [3] = '{32'h0, 32'h2, 32'h1};
  localparam logic [31:0] RT [3] = '{32'h0, 32'h1, 32'h0};
  localparam logic [31:0] EXP [3] = '{32'h1, 32'h2, 32'h3};
  localparam logic [31:0] PER [3] = '{32'd640, 32'd800, 32'd1280};
  pmc_capture DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .dma_req, .dma_addr, .dma_wdata, .dma_ack, .gpio_out, .gpio_oe,
    .pad_in, .pad_out, .pad_oe, .irq);
  pmc_mic_model mic (.pclk(pclk), .clk_pin(pad_out[3]), .clk_en(pad_oe[3]), .data(din));
  assign pad_in = {27'h0, din, 4'h0};
  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Memory acks, logs words; hang guard
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    dma_ack <= dma_req && !dma_ack;
    if (dma_req && dma_ack)
    begin
      w_addr <= dma_addr;
      w_data <= dma_wdata;
      t_prev <= t_last;
      t_last <= cyc;
      n_words <= n_words + 1;
    end
    if (cyc == 40000)
    begin
      n_fail++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // One APB transfer held until pready
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic poll(input logic [11:0] a);
    do apb(a, 1'b0, 32'h0); while (rd[0] !== 1'b1);
  endtask : poll
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial
  begin
    {psel, penable, pwrite, dma_ack, presetn} = 5'h0;
    paddr = 12'h0; pwdata = 32'h0; cyc = 0; n_words = 0; t_last = 0; t_prev = 0;
    gpio_out = 32'h100; gpio_oe = 32'h108;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(pmc_pkg::OFF_PSEL_CLK, 1'b0, 32'h0); chk(rd, pmc_pkg::RST_PSEL);
    apb(pmc_pkg::OFF_LEFT_GAIN, 1'b0, 32'h0); chk(rd, {25'h0, pmc_pkg::RST_GAIN});
    apb(12'h0FC, 1'b0, 32'h0); chk({31'h0, err}, 32'h1);
    chk(pad_out, gpio_out);
    $display("test reset done");
    apb(pmc_pkg::OFF_PSEL_CLK, 1'b1, 32'h3);
    apb(pmc_pkg::OFF_PSEL_DIN, 1'b1, 32'h4);
    apb(pmc_pkg::OFF_INTEN, 1'b1, 32'h7);
    apb(pmc_pkg::OFF_BUF_CNT, 1'b1, 32'h8);
    apb(pmc_pkg::OFF_ENABLE, 1'b1, 32'h1);
    // Stereo, swapped stereo at ratio 80, mono
    for (int i = 0; i < 3; i++)
    begin
      apb(pmc_pkg::OFF_MODE, 1'b1, MD[i]);
      apb(pmc_pkg::OFF_RATIO, 1'b1, RT[i]);
      apb(pmc_pkg::OFF_BUF_PTR, 1'b1, BASE);
      apb(pmc_pkg::OFF_TASK_START, 1'b1, 32'h1);
      apb(pmc_pkg::OFF_EV_STARTED, 1'b0, 32'h0); chk(rd, 32'h1);
      apb(pmc_pkg::OFF_EV_STARTED, 1'b1, 32'h0);
      apb(pmc_pkg::OFF_BUF_PTR, 1'b1, BASE + 32'h100);
      poll(pmc_pkg::OFF_EV_END);
      chk(w_addr, BASE + 32'hC);
      // Last word only, the first ones are settling
      chk({30'h0, $signed(w_data[31:16]) > 0, $signed(w_data[15:0]) > 0}, EXP[i]);
      chk(32'(t_last - t_prev), PER[i]);
      chk({31'h0, irq}, 32'h1);
      apb(pmc_pkg::OFF_EV_STARTED, 1'b0, 32'h0); chk(rd, 32'h1);
      apb(pmc_pkg::OFF_EV_END, 1'b1, 32'h0);
      apb(pmc_pkg::OFF_EV_STARTED, 1'b1, 32'h0);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      n = n_words;
      while (n_words == n) @(posedge pclk);
      chk(w_addr, BASE + 32'h100);
      apb(pmc_pkg::OFF_TASK_STOP, 1'b1, 32'h1);
      poll(pmc_pkg::OFF_EV_STOPPED);
      chk({31'h0, dma_req}, 32'h0);
      apb(pmc_pkg::OFF_EV_STOPPED, 1'b1, 32'h0);
      apb(pmc_pkg::OFF_EV_END, 1'b1, 32'h0);
      apb(pmc_pkg::OFF_EV_STARTED, 1'b1, 32'h0);
      $display("test mode %0d done", i);
    end
    apb(pmc_pkg::OFF_ENABLE, 1'b1, 32'h0);
    repeat (2) @(posedge pclk);
    chk(pad_out, gpio_out);
    $display("test disable done");
    stop_test();
  end
endmodule : pmc_capture_test
